// ---- byte_ram.sv ----
// Byte memory with one write port and a registered read port.
// Assumes contents need no reset; read data lag the address by one edge.
`timescale 1ns/100ps
`default_nettype none
module byte_ram #(parameter int AW = 10, parameter int DW = 8) (
	// Clock
	input wire logic clk,
	// Memory port
	mem_port_if.mem port
);
	logic [DW-1:0] mem_r [0:(1<<AW)-1];
	logic [DW-1:0] rd_r;

	always_ff @(posedge clk) begin
		if (port.wr_en) begin
			mem_r[port.wr_addr] <= port.wr_data;
		end
		rd_r <= mem_r[port.rd_addr];
	end

	assign port.rd_data = rd_r;
endmodule
`default_nettype wire

// ---- eeprom_pkg.sv ----
// Shared constants and types of the serial memory slave.
// Assumes a 250 MHz system clock and a 1,024 x 8 array.
package eeprom_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam int PAGE_W = 4;
	localparam int SYNC_W = 5;
	localparam int BUSY_CNT_W = 20;
	// Device-type field of the slave address; value is arbitrary
	localparam logic [3:0] DEV_TYPE_ID = 4'hB;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 10'h000;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_BYTE = 4'h8;
	localparam logic [4:0] COMMIT_END = 5'h10;
	// Internal write time, least value, and its cycle count
	localparam int CLK_PERIOD_PS = 4000;
	localparam int INTERNAL_WRITE_TIME_US = 5;
	localparam int WRITE_CYCLES_DFLT =
		(INTERNAL_WRITE_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_WORD = 3'b010,
		ST_DATA = 3'b011,
		ST_TX = 3'b100,
		ST_MACK = 3'b101,
		ST_WAIT_STOP = 3'b110
	} slave_state_e;
endpackage

// ---- mem_port_if.sv ----
// Write port and registered read port between the slave and its memories.
// Assumes one clock; read data arrive one edge after the read address.
`timescale 1ns/100ps
`default_nettype none
interface mem_port_if #(parameter int AW = 10, parameter int DW = 8);
	logic wr_en;
	logic [AW-1:0] wr_addr;
	logic [DW-1:0] wr_data;
	logic [AW-1:0] rd_addr;
	logic [DW-1:0] rd_data;
	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ---- pin_sync.sv ----
// Three-stage synchroniser with agreement filter for pin-level inputs.
// Assumes inputs come from outside the clk domain.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(parameter int W = 5) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Raw and filtered levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] q_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// A level is taken only once the last two stages agree
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q_r <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_r[i] == s3_r[i]) begin
					q_r[i] <= s3_r[i];
				end
			end
		end
	end

	assign q = q_r;
endmodule
`default_nettype wire

// ---- serial_eeprom_two_wire_slave.sv ----
// Two-wire serial slave of a 1,024 x 8 nonvolatile memory with page buffer.
// Assumes an external pull-up on the data line and a bus master on the far side.
//
// Overview of operation
// R1: Data falling while clock high is a START.
// R2: Data rising while clock high is a STOP.
// R3: Master starts only on an idle bus, both lines high.
// R4: One bit per clock; data changes only while clock is low.
// R5: After eight bits the receiver pulls data low on the ninth clock.
// R6: Acknowledge a matching address byte and every later byte of a write.
// R7: Read: send eight bits, sample ack; continue on ack, else await STOP.
// R8: Respond only when the top four address bits equal the device type.
// R9: Fifth address bit must equal the device-select pin level.
// R10: Sixth and seventh address bits are the two upper memory address bits.
// R11: Last address bit: one reads, zero writes.
// R12: Byte write is address, word address, one data byte; STOP starts the write.
// R13: During the internal write the inputs are ignored.
// R14: Page write takes up to sixteen data bytes, all acknowledged, one write cycle.
// R15: Page write increments only the four low address bits.
// R16: More than sixteen bytes wrap within the page and overwrite earlier ones.
// R17: While writing, ignore START and withhold acknowledge; acknowledge again after.
// R18: Master polls with write-direction address until acknowledged.
// R19: Write-protect high inhibits array writes; low permits them.
// R20: Data pin is open drain; read bits change after the clock falls.
// R21: A read-direction address starts one of four read variants.
// R22: Address counter holds last address plus one; current read advances it.
// R23: Random read loads the counter with a write header, then repeated START.
// R24: Sequential reads increment all address bits, wrapping at the top.
// R25: Internal write duration is a configurable count of system clocks.
// R26: START or STOP aborts a partial byte and returns to address wait.
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_two_wire_slave #(
	parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES_DFLT
) (
	// System clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Two-wire link
	input wire logic serial_clk,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Straps
	input wire logic write_protect_in,
	input wire logic device_select_pin
);
	import eeprom_pkg::*;

	function automatic logic [ADDR_W-1:0] page_next(input logic [ADDR_W-1:0] a);
		page_next = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 4'h1};
	endfunction

	// Link side: sample data on the rising serial clock
	logic cap_bit_r;
	logic cap_tgl_r;

	always_ff @(posedge serial_clk or negedge arst_n) begin
		if (!arst_n) begin
			cap_bit_r <= 1'b0;
			cap_tgl_r <= 1'b0;
		end else begin
			cap_bit_r <= sda_in; // [R4]
			cap_tgl_r <= ~cap_tgl_r;
		end
	end

	// System side: filtered pin levels and the bit toggle
	logic [SYNC_W-1:0] sync_q;
	logic tgl_f, scl_f, sda_f, wp_f, dsel_f;
	logic tgl_q_r, scl_q_r, sda_q_r;

	pin_sync #(.W(SYNC_W)) u_sync (
		.clk(clk),
		.arst_n(arst_n),
		.d({cap_tgl_r, serial_clk, sda_in, write_protect_in, device_select_pin}),
		.q(sync_q)
	);

	assign {tgl_f, scl_f, sda_f, wp_f, dsel_f} = sync_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tgl_q_r <= 1'b0;
			scl_q_r <= 1'b0;
			sda_q_r <= 1'b0;
		end else begin
			tgl_q_r <= tgl_f;
			scl_q_r <= scl_f;
			sda_q_r <= sda_f;
		end
	end

	// Both lines share one pipeline; zero hold time on the bus stays a hazard
	logic start_ev, stop_ev, scl_fall, bit_ev;
	assign start_ev = scl_f && scl_q_r && sda_q_r && !sda_f; // [R1] [R3]
	assign stop_ev = scl_f && scl_q_r && !sda_q_r && sda_f; // [R2]
	assign scl_fall = scl_q_r && !scl_f;
	// Captured bit is held for a whole clock period, far longer than the sync delay
	assign bit_ev = tgl_f != tgl_q_r;

	// Memories
	mem_port_if #(.AW(ADDR_W), .DW(DATA_W)) arr_if ();
	mem_port_if #(.AW(PAGE_W), .DW(DATA_W)) pbuf_if ();

	byte_ram #(.AW(ADDR_W), .DW(DATA_W)) u_array (
		.clk(clk),
		.port(arr_if.mem)
	);

	byte_ram #(.AW(PAGE_W), .DW(DATA_W)) u_page (
		.clk(clk),
		.port(pbuf_if.mem)
	);

	// Slave state
	slave_state_e state_r;
	logic [3:0] bit_cnt_r;
	logic [DATA_W-1:0] shift_r;
	logic [DATA_W-1:0] tx_sh_r;
	logic ack_pend_r, ack_ph_r, tx_load_r;
	logic [1:0] hi_r;
	logic [ADDR_W-1:0] addr_r;
	logic [15:0] mask_r;
	logic busy_r;
	logic [BUSY_CNT_W-1:0] busy_cnt_r;
	logic [4:0] cidx_r;
	logic [PAGE_W-1:0] cidx_d_r;
	logic commit_v_r;
	logic [ADDR_W-PAGE_W-1:0] page_r;
	logic sda_oe_r, sda_out_r;

	logic rx_state, byte_done, match, tx_load, data_byte;
	logic [DATA_W-1:0] rx_byte;

	assign rx_state = (state_r == ST_ADDR) || (state_r == ST_WORD) || (state_r == ST_DATA);
	assign byte_done = bit_ev && rx_state && !ack_pend_r && !ack_ph_r && bit_cnt_r == BIT_LAST;
	assign rx_byte = {shift_r[DATA_W-2:0], cap_bit_r};
	assign match = rx_byte[7:4] == DEV_TYPE_ID && rx_byte[3] == dsel_f; // [R8] [R9]
	assign data_byte = byte_done && state_r == ST_DATA;
	assign tx_load = scl_fall && state_r == ST_TX && (ack_ph_r || tx_load_r);

	// Sequencer: states, bit counting, received bytes
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= ST_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r <= '0;
			ack_pend_r <= 1'b0;
			ack_ph_r <= 1'b0;
			tx_load_r <= 1'b0;
			hi_r <= 2'b00;
		end else if (busy_r) begin
			state_r <= ST_IDLE; // [R13] [R17]
			ack_pend_r <= 1'b0;
			ack_ph_r <= 1'b0;
			tx_load_r <= 1'b0;
		end else if (start_ev) begin
			state_r <= ST_ADDR; // [R26]
			bit_cnt_r <= 4'h0;
			ack_pend_r <= 1'b0;
			ack_ph_r <= 1'b0;
			tx_load_r <= 1'b0;
		end else if (stop_ev) begin
			state_r <= ST_IDLE; // [R26]
			ack_pend_r <= 1'b0;
			ack_ph_r <= 1'b0;
			tx_load_r <= 1'b0;
		end else begin
			if (scl_fall && ack_pend_r) begin
				ack_pend_r <= 1'b0;
				ack_ph_r <= 1'b1;
			end else if (scl_fall && ack_ph_r) begin
				ack_ph_r <= 1'b0;
			end
			if (tx_load) begin
				tx_load_r <= 1'b0;
				bit_cnt_r <= 4'h0;
			end
			case (state_r)
				ST_ADDR, ST_WORD, ST_DATA: begin
					if (bit_ev && !ack_pend_r && !ack_ph_r) begin
						shift_r <= rx_byte;
						bit_cnt_r <= (bit_cnt_r == BIT_LAST) ? 4'h0 : bit_cnt_r + 4'h1;
					end
					if (byte_done) begin
						if (state_r != ST_ADDR) begin
							ack_pend_r <= 1'b1; // [R6] [R14]
							state_r <= ST_DATA;
						end else if (match) begin
							ack_pend_r <= 1'b1; // [R6]
							hi_r <= rx_byte[2:1]; // [R10]
							state_r <= rx_byte[0] ? ST_TX : ST_WORD; // [R11] [R21]
						end else begin
							state_r <= ST_IDLE; // [R8]
						end
					end
				end
				ST_TX: begin
					if (bit_ev && !ack_pend_r && !ack_ph_r && !tx_load_r) begin
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
					if (scl_fall && !tx_load && bit_cnt_r == BIT_BYTE) begin
						state_r <= ST_MACK; // [R7]
					end
				end
				ST_MACK: begin
					if (bit_ev) begin
						if (!cap_bit_r) begin
							state_r <= ST_TX; // [R7]
							tx_load_r <= 1'b1;
						end else begin
							state_r <= ST_WAIT_STOP; // [R7]
						end
					end
				end
				ST_IDLE, ST_WAIT_STOP: begin
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Data pin drive; changes follow a falling serial clock, except the release on START, STOP or busy
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sda_oe_r <= 1'b0;
			sda_out_r <= 1'b0;
			tx_sh_r <= '0;
		end else if (busy_r || start_ev || stop_ev) begin
			sda_oe_r <= 1'b0; // [R17]
		end else if (scl_fall) begin
			if (ack_pend_r) begin
				sda_oe_r <= 1'b1; // [R5]
			end else if (tx_load) begin
				tx_sh_r <= arr_if.rd_data;
				sda_oe_r <= ~arr_if.rd_data[DATA_W-1]; // [R20]
			end else if (state_r == ST_TX && !tx_load_r && bit_cnt_r != BIT_BYTE) begin
				tx_sh_r <= {tx_sh_r[DATA_W-2:0], 1'b0};
				sda_oe_r <= ~tx_sh_r[DATA_W-2]; // [R20] [R4]
			end else begin
				sda_oe_r <= 1'b0; // [R5]
			end
		end
	end

	// Address counter
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			addr_r <= ADDR_RESET;
		end else if (!busy_r && !start_ev && !stop_ev) begin
			if (byte_done && state_r == ST_WORD) begin
				addr_r <= {hi_r, rx_byte}; // [R10] [R23]
			end else if (data_byte) begin
				addr_r <= page_next(addr_r); // [R15] [R16]
			end else if (tx_load) begin
				addr_r <= addr_r + 10'h001; // [R22] [R24]
			end
		end
	end

	// Page buffer fill; a later byte at the same slot overwrites the earlier one
	assign pbuf_if.wr_en = data_byte && !busy_r && !start_ev && !stop_ev; // [R16]
	assign pbuf_if.wr_addr = addr_r[PAGE_W-1:0];
	assign pbuf_if.wr_data = rx_byte;
	assign pbuf_if.rd_addr = cidx_r[PAGE_W-1:0];
	assign arr_if.rd_addr = addr_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mask_r <= 16'h0000;
		end else if (pbuf_if.wr_en) begin
			mask_r[addr_r[PAGE_W-1:0]] <= 1'b1; // [R14]
		end else if ((!busy_r && start_ev) || (busy_r && !commit_v_r
			&& cidx_r == COMMIT_END)) begin
			// Kept through STOP: the commit that STOP launches still needs the filled slots
			mask_r <= 16'h0000;
		end
	end

	// Self-timed write: copy flagged bytes while busy is held for the full count
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_r <= 1'b0;
			busy_cnt_r <= '0;
			cidx_r <= 5'h00;
			cidx_d_r <= 4'h0;
			commit_v_r <= 1'b0;
			page_r <= '0;
		end else if (!busy_r) begin
			if (stop_ev && state_r == ST_DATA && mask_r != 16'h0000 && !wp_f) begin
				busy_r <= 1'b1; // [R12] [R19]
				busy_cnt_r <= '0;
				cidx_r <= 5'h00;
				commit_v_r <= 1'b0;
				page_r <= addr_r[ADDR_W-1:PAGE_W];
			end
		end else begin
			commit_v_r <= cidx_r != COMMIT_END;
			cidx_d_r <= cidx_r[PAGE_W-1:0];
			if (cidx_r != COMMIT_END) begin
				cidx_r <= cidx_r + 5'h01;
			end
			if (busy_cnt_r == BUSY_CNT_W'(WRITE_CYCLES - 1)) begin
				busy_r <= 1'b0; // [R25] [R17]
			end else begin
				busy_cnt_r <= busy_cnt_r + 1'b1;
			end
		end
	end

	// Count must be at least the 17-cycle copy so no byte is lost
	assign arr_if.wr_en = busy_r && commit_v_r && mask_r[cidx_d_r]; // [R14]
	assign arr_if.wr_addr = {page_r, cidx_d_r};
	assign arr_if.wr_data = pbuf_if.rd_data;

	assign sda_oe = sda_oe_r;
	assign sda_out = sda_out_r;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence addr_hit_s;
		byte_done && state_r == ST_ADDR && match;
	endsequence

	sequence master_nack_s;
		state_r == ST_MACK && bit_ev && cap_bit_r && !busy_r && !start_ev && !stop_ev;
	endsequence

	start_abort_a: assert property (start_ev && !busy_r |=> state_r == ST_ADDR && bit_cnt_r == 4'h0) // [R1]
		else $error("start did not restart address phase");
	stop_idle_a: assert property (stop_ev |=> state_r == ST_IDLE && !sda_oe_r) // [R2]
		else $error("stop did not return to idle");
	drive_edge_a: assert property ($rose(sda_oe_r) |-> $past(scl_fall)) // [R4]
		else $error("data drive began outside clock low");
	addr_ack_a: assert property (addr_hit_s |-> ##[1:1000] (sda_oe_r || start_ev || stop_ev || busy_r)) // [R6]
		else $error("matching address not acknowledged");
	type_miss_a: assert property (byte_done && state_r == ST_ADDR && !match && !start_ev && !stop_ev
		|=> state_r == ST_IDLE) // [R8]
		else $error("foreign address accepted");
	busy_quiet_a: assert property (busy_r |-> !sda_oe_r && state_r == ST_IDLE) // [R13]
		else $error("bus answered during internal write");
	page_wrap_a: assert property (pbuf_if.wr_en |=> addr_r == page_next($past(addr_r))) // [R15]
		else $error("page address step wrong");
	protect_hold_a: assert property ($rose(busy_r) |-> $past(!wp_f)) // [R19]
		else $error("write started while protected");
	commit_mask_a: assert property ($rose(busy_r) |-> mask_r != 16'h0000) // [R12]
		else $error("write cycle started with no buffered byte");
	nack_wait_a: assert property (master_nack_s |=> state_r == ST_WAIT_STOP ##1 !sda_oe_r) // [R7]
		else $error("transmit continued after no acknowledge");
	seq_step_a: assert property (tx_load |=> addr_r == $past(addr_r) + 10'h001) // [R24]
		else $error("read counter did not advance");
	busy_len_a: assert property ($fell(busy_r) |-> $past(busy_cnt_r) == BUSY_CNT_W'(WRITE_CYCLES - 1)) // [R25]
		else $error("internal write length wrong");
endmodule
`default_nettype wire

// ---- serial_eeprom_two_wire_slave_bench.sv ----
// Self-checking bench of the two-wire serial memory slave against a behavioural array model.
// Assumes the master model in two_wire_master.sv and the design package.
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_two_wire_slave_bench import eeprom_pkg::*;;
	// Busy long enough that the first poll after a write lands inside it
	localparam int WR_CYC = 1000;
	logic clk, arst_n, wp, sel, sda_out, sda_oe, scl, m_low, sda_wire;
	logic [7:0] model [0:1023];
	logic [9:0] cnt;
	int fail_count, checked;
	// Open-drain wire with pull-up
	assign sda_wire = ~(m_low | (sda_oe & ~sda_out));
	serial_eeprom_two_wire_slave #(.WRITE_CYCLES(WR_CYC)) serial_eeprom_two_wire_slave_inst (
		.clk(clk), .arst_n(arst_n), .serial_clk(scl), .sda_in(sda_wire), .sda_out(sda_out),
		.sda_oe(sda_oe), .write_protect_in(wp), .device_select_pin(sel));
	two_wire_master two_wire_master_inst (.sda_wire(sda_wire), .scl(scl), .sda_low(m_low));
	initial clk = 1'b0;
	always #2 clk = ~clk;
	task automatic chk_bit(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic print_verdict();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic hdr(input logic [9:0] a, input logic rw, output logic ack);
		logic [7:0] q;
		logic r;
		two_wire_master_inst.start();
		two_wire_master_inst.xb({DEV_TYPE_ID, sel, a[9:8], rw}, 1'b1, q, r);
		ack = ~r;
	endtask
	task automatic bad(input logic [7:0] h);
		logic [7:0] q;
		logic r;
		two_wire_master_inst.start();
		two_wire_master_inst.xb(h, 1'b1, q, r);
		two_wire_master_inst.stop();
		chk_bit("foreign address nack", 1'b1, r);
	endtask
	task automatic wr_seq(input logic [9:0] a, input int n);
		logic [7:0] q, d;
		logic r, ack;
		hdr(a, 1'b0, ack);
		chk_bit("address ack", 1'b1, ack);
		two_wire_master_inst.xb(a[7:0], 1'b1, q, r);
		chk_bit("word ack", 1'b0, r);
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			two_wire_master_inst.xb(d, 1'b1, q, r);
			chk_bit("data ack", 1'b0, r);
			if (!wp) model[{a[9:4], 4'(a[3:0] + i)}] = d;
		end
		cnt = {a[9:4], 4'(a[3:0] + n)};
		two_wire_master_inst.stop();
		// A protected write starts no cycle, so the first poll is answered at once
		hdr(cnt, 1'b0, ack);
		two_wire_master_inst.stop();
		chk_bit("first poll ack", wp, ack);
		for (int i = 0; i < 4 && !ack; i++) begin
			hdr(cnt, 1'b0, ack);
			two_wire_master_inst.stop();
		end
		chk_bit("poll ack", 1'b1, ack);
	endtask
	task automatic rd_seq(input logic [9:0] a, input int n, input logic rnd);
		logic [7:0] q;
		logic r, ack;
		if (rnd) begin
			hdr(a, 1'b0, ack);
			two_wire_master_inst.xb(a[7:0], 1'b1, q, r);
			cnt = a;
		end
		hdr(cnt, 1'b1, ack);
		chk_bit("read address ack", 1'b1, ack);
		for (int i = 0; i < n; i++) begin
			two_wire_master_inst.xb(8'hFF, i == n - 1, q, r);
			chk_byte("read data", model[cnt], q);
			chk_bit("data out level", 1'b0, sda_out);
			cnt++;
		end
		two_wire_master_inst.stop();
	endtask
	// Bus traffic needs roughly 240 us; a hang is cut at 360 us, 90,000 clocks
	initial begin
		#360000;
		fail_count++;
		$display("ERROR watchdog expected completion seen timeout");
		print_verdict();
	end
	initial begin
		logic [9:0] a;
		logic r;
		fail_count = 0;
		checked = 0;
		arst_n = 1'b0;
		wp = 1'b0;
		sel = 1'b0;
		cnt = 10'h000;
		void'($urandom(7080));
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		sel <= 1'($urandom);
		repeat (12) @(posedge clk);
		bad({~DEV_TYPE_ID, sel, 3'h0});
		bad({DEV_TYPE_ID, ~sel, 3'h0});
		a = 10'($urandom);
		wr_seq(a, 1);
		rd_seq(a, 1, 1'b1);
		a = {6'($urandom), 4'hC};
		wr_seq(a, 18);
		rd_seq(cnt, 2, 1'b0);
		rd_seq({a[9:4], 4'h0}, 16, 1'b1);
		wr_seq(10'h3FF, 1);
		wr_seq(10'h000, 1);
		rd_seq(10'h3FF, 2, 1'b1);
		@(posedge clk);
		wp <= 1'b1;
		wr_seq(10'h3FF, 1);
		@(posedge clk);
		wp <= 1'b0;
		two_wire_master_inst.start();
		repeat (3) two_wire_master_inst.bitx(1'b0, r);
		rd_seq(10'h3FF, 1, 1'b1);
		print_verdict();
	end
endmodule
`default_nettype wire

// ---- two_wire_master.sv ----
// Behavioural two-wire bus master that drives the clock and pulls the data wire low.
// Assumes a pull-up on the data wire; the resolved level comes back on sda_wire.
`timescale 1ns/100ps
`default_nettype none
module two_wire_master (
	// Bus lines
	input wire logic sda_wire,
	output logic scl,
	output logic sda_low
);
	logic lclk;
	// Link clock of 32 ns, offset so its edges never meet the system clock's edges
	initial begin
		lclk = 1'b0;
		scl = 1'b1;
		sda_low = 1'b0;
		#3.3;
		forever #16 lclk = ~lclk;
	end
	// Three link ticks a phase, so the design sees at least 24 system clocks per phase
	task automatic ph();
		repeat (3) @(posedge lclk);
	endtask
	// Release data, raise clock, then drop data: idle or repeated start
	task automatic start();
		ph();
		sda_low <= 1'b0;
		ph();
		scl <= 1'b1;
		ph();
		sda_low <= 1'b1;
		ph();
		scl <= 1'b0;
	endtask
	// Data rises while clock high, leaving the bus idle
	task automatic stop();
		ph();
		sda_low <= 1'b1;
		ph();
		scl <= 1'b1;
		ph();
		sda_low <= 1'b0;
		ph();
	endtask
	// Data moves mid low phase, sampled at the end of the high phase
	task automatic bitx(input logic b, output logic r);
		ph();
		sda_low <= ~b;
		ph();
		scl <= 1'b1;
		ph();
		r = sda_wire;
		scl <= 1'b0;
	endtask
	// Eight bits MSB first, then the acknowledge clock
	task automatic xb(input logic [7:0] d, input logic b9, output logic [7:0] q, output logic r9);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], q[i]);
		end
		bitx(b9, r9);
	endtask
endmodule
`default_nettype wire
